// ==== hw/tx_link_config_registers.sv ====
// Link configuration register bank of the transmitter with its AXI4-Lite slave.
//
// Behaviour
// - Registers read and written over AXI4-Lite.
// - Single bits read as old or new.
// - Lock bit freezes multi-bit status during reads.
// - Multi-bit config applied only on toggle.
// - Undefined bits read as zero.
// - Rate code selects 1.62, 2.7, 5.4 Gbps.
// - Lane count field, values 1, 2, 4.
// - Bit selects enhanced or normal framing.
// - Training field selects training pattern.
// - Quality field selects test pattern.
// - Bit bypasses the scrambler.
// - Bit applies half percent down-spread.
// - Soft reset register write-only, resets video.
// - Gate low sends only stuffing symbols.
// - Stream gate low sends blanking, no video.
// - Stream gate change waits for vsync boundary.
// - Link clock is bit rate over twenty.
`timescale 1ns/10ps
`include "tx_link_cfg_defs.svh"
module tx_link_config_registers #(
    parameter int FIFO_DEPTH = 32,
    parameter bit SUPPORTS_V12 = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic vsyncStart,
    input wire logic [15:0] symbolStatus,
    output tx_link_cfg_pkg::link_config_type linkConfig,
    output logic [6:0] linkClockRatio,
    output logic videoResetPulse
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // The commit FIFO wraps its pointers by bit width, so a depth that is not a power of two
    // would lose committed words.
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("FIFO_DEPTH must be at least 2");
        end
        if ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
            $error("FIFO_DEPTH must be a power of two");
        end
        if ($bits(tx_link_cfg_pkg::link_config_type) != `RATE_CODE_W + `LANE_COUNT_W + 9) begin
            $error("link configuration layout does not match the field widths");
        end
        if (`LINK_RATE_DIVISOR > 127) begin
            $error("link rate divisor does not fit the ratio output");
        end
    end

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    localparam int CFG_W = $bits(tx_link_cfg_pkg::link_config_type);
    logic [11:0] wrAddr_q;
    logic haveAw_q;
    logic [31:0] wrData_q;
    logic [3:0] wrStrb_q;
    logic haveW_q;
    logic doWrite;
    logic wrHit;
    assign doWrite = haveAw_q && haveW_q && !bvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            haveAw_q <= 1'b0;
            wrAddr_q <= '0;
        end else if (awvalid && awready) begin
            haveAw_q <= 1'b1;
            wrAddr_q <= awaddr;
        end else if (doWrite) begin
            haveAw_q <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            haveW_q <= 1'b0;
            wrData_q <= '0;
            wrStrb_q <= '0;
        end else if (wvalid && wready) begin
            haveW_q <= 1'b1;
            wrData_q <= wdata;
            wrStrb_q <= wstrb;
        end else if (doWrite) begin
            haveW_q <= 1'b0;
        end
    end
    // Ready stays low after each handshake until the held word has been written, so a valid that is still held
    // is never taken twice.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            awready <= !haveAw_q && !(awvalid && awready);
            wready <= !haveW_q && !(wvalid && wready);
        end
    end
    always_comb begin
        case (wrAddr_q)
            `OFS_LINK_RATE_CODE, `OFS_ACTIVE_LANE_COUNT, `OFS_FRAMING_SELECT,
            `OFS_TRAINING_SELECT, `OFS_QUALITY_SELECT, `OFS_SCRAMBLER_BYPASS,
            `OFS_CLOCK_SPREAD, `OFS_SOFT_VIDEO_RESET, `OFS_LINK_OUTPUT_GATE,
            `OFS_VIDEO_STREAM_GATE, `OFS_CONFIG_COMMIT, `OFS_STATUS_LOCK: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end
    // Unmapped offsets still answer, so a stray access never stalls the host.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= `AXI_RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shadow registers seen by software
    // ------------------------------------------------------------
    tx_link_cfg_pkg::link_config_type shadow_q;
    logic commitToggle_q;
    logic statusLock_q;
    logic lowByte;
    // Every field sits in byte lane 0, so the other strobes are ignored.
    assign lowByte = doWrite && wrStrb_q[0];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shadow_q <= tx_link_cfg_pkg::link_config_type'(`FIELD_RESET);
        end else if (lowByte) begin
            case (wrAddr_q)
                `OFS_LINK_RATE_CODE: shadow_q.linkRateCode <= wrData_q[7:0];
                `OFS_ACTIVE_LANE_COUNT: shadow_q.laneCount <= wrData_q[4:0];
                `OFS_FRAMING_SELECT: shadow_q.enhancedFraming <= wrData_q[0];
                `OFS_TRAINING_SELECT: begin
                    shadow_q.trainingPattern <= tx_link_cfg_pkg::training_type'(wrData_q[1:0]);
                end
                `OFS_QUALITY_SELECT: begin
                    shadow_q.qualityPattern <= tx_link_cfg_pkg::quality_type'(wrData_q[1:0]);
                end
                `OFS_SCRAMBLER_BYPASS: shadow_q.scramblerBypass <= wrData_q[0];
                `OFS_CLOCK_SPREAD: shadow_q.clockSpread <= wrData_q[0];
                `OFS_LINK_OUTPUT_GATE: shadow_q.linkOutputGate <= wrData_q[0];
                `OFS_VIDEO_STREAM_GATE: shadow_q.videoStreamGate <= wrData_q[0];
                default: shadow_q <= shadow_q;
            endcase
        end
    end

    // Writing any value flips the commit toggle; software need not track its phase.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            commitToggle_q <= 1'b0;
        end else if (lowByte && wrAddr_q == `OFS_CONFIG_COMMIT) begin
            commitToggle_q <= !commitToggle_q;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusLock_q <= 1'b0;
        end else if (lowByte && wrAddr_q == `OFS_STATUS_LOCK) begin
            statusLock_q <= wrData_q[0];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            videoResetPulse <= 1'b0;
        end else begin
            videoResetPulse <= lowByte && wrAddr_q == `OFS_SOFT_VIDEO_RESET && wrData_q[0];
        end
    end

    // ------------------------------------------------------------
    // Commit path to the link side
    // ------------------------------------------------------------
    // Committed words queue through the FIFO so several commits in a row are kept in order.
    logic [CFG_W:0] fifoIn;
    logic [CFG_W:0] fifoOut;
    logic fifoInReady;
    logic fifoOutValid;
    logic commitSeen_q;
    logic commitPending;
    assign commitPending = commitToggle_q != commitSeen_q;
    assign fifoIn = {1'b1, shadow_q};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            commitSeen_q <= 1'b0;
        end else if (commitPending && fifoInReady) begin
            commitSeen_q <= commitToggle_q;
        end
    end
    cfg_fifo #(.WIDTH(CFG_W + 1), .DEPTH(FIFO_DEPTH)) commitFifo (
        .clk(clk),
        .rst(rst),
        .inValid(commitPending),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(1'b1),
        .outData(fifoOut)
    );
    // Two-stage capture stands in for the domain crossing so lane output never sees a torn word.
    tx_link_cfg_pkg::link_config_type stage1_q;
    tx_link_cfg_pkg::link_config_type applied_q;
    logic stage1Valid_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_q <= tx_link_cfg_pkg::link_config_type'(`FIELD_RESET);
            stage1Valid_q <= 1'b0;
        end else begin
            stage1Valid_q <= fifoOutValid && fifoOut[CFG_W];
            if (fifoOutValid) begin
                stage1_q <= fifoOut[CFG_W-1:0];
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            applied_q <= tx_link_cfg_pkg::link_config_type'(`FIELD_RESET);
        end else if (stage1Valid_q) begin
            applied_q <= stage1_q;
        end
    end

    // ------------------------------------------------------------
    // Stream gate and link-side outputs
    // ------------------------------------------------------------
    logic streamApplied;
    frame_gate streamGate (
        .clk(clk),
        .rst(rst),
        .request(applied_q.videoStreamGate),
        .frameStart(vsyncStart),
        .applied(streamApplied)
    );
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            linkConfig <= tx_link_cfg_pkg::link_config_type'(`FIELD_RESET);
        end else begin
            linkConfig <= applied_q;
            // Rate 5.4 Gbps is refused on cores without the newer protocol version.
            if (!SUPPORTS_V12 && applied_q.linkRateCode == `RATE_CODE_5G40) begin
                linkConfig.linkRateCode <= `RATE_CODE_2G70;
            end
            if (!SUPPORTS_V12 && applied_q.trainingPattern == tx_link_cfg_pkg::TRAIN_EQUALIZE_3) begin
                linkConfig.trainingPattern <= tx_link_cfg_pkg::TRAIN_EQUALIZE_2;
            end
            linkConfig.videoStreamGate <= streamApplied;
        end
    end
    // Ratio of link bit rate to link clock, reported for the clocking logic.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            linkClockRatio <= '0;
        end else begin
            linkClockRatio <= 7'(`LINK_RATE_DIVISOR);
        end
    end

    // ------------------------------------------------------------
    // Status capture and read channel
    // ------------------------------------------------------------
    logic [15:0] statusHeld_q;
    logic [31:0] readWord;
    logic rdHit;
    // While locked the held copy keeps the value of the last unlocked cycle, so the host
    // reads all sixteen bits from one instant.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusHeld_q <= '0;
        end else if (!statusLock_q) begin
            statusHeld_q <= symbolStatus;
        end
    end
    // Reserved bits fall out of the zero default; unmapped offsets answer with an error.
    always_comb begin
        readWord = '0;
        rdHit = 1'b1;
        case (araddr)
            `OFS_LINK_RATE_CODE: readWord[7:0] = shadow_q.linkRateCode;
            `OFS_ACTIVE_LANE_COUNT: readWord[4:0] = shadow_q.laneCount;
            `OFS_FRAMING_SELECT: readWord[0] = shadow_q.enhancedFraming;
            `OFS_TRAINING_SELECT: readWord[1:0] = shadow_q.trainingPattern;
            `OFS_QUALITY_SELECT: readWord[1:0] = shadow_q.qualityPattern;
            `OFS_SCRAMBLER_BYPASS: readWord[0] = shadow_q.scramblerBypass;
            `OFS_CLOCK_SPREAD: readWord[0] = shadow_q.clockSpread;
            `OFS_SOFT_VIDEO_RESET: readWord = '0;
            `OFS_LINK_OUTPUT_GATE: readWord[0] = shadow_q.linkOutputGate;
            `OFS_VIDEO_STREAM_GATE: readWord[0] = shadow_q.videoStreamGate;
            `OFS_CONFIG_COMMIT: readWord[0] = commitToggle_q;
            `OFS_STATUS_LOCK: readWord[0] = statusLock_q;
            `OFS_LINK_STATUS: begin
                readWord[15:0] = statusHeld_q;
                readWord[16] = streamApplied;
                readWord[17] = commitPending;
            end
            default: rdHit = 1'b0;
        endcase
    end
    // Only one read is outstanding; the address channel reopens after the data is taken.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b0;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `AXI_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= rdHit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// ==== hw/tx_link_cfg_defs.svh ====
// Register offsets, field positions, reset values and codes of the link configuration bank.
`ifndef TX_LINK_CFG_DEFS_SVH
`define TX_LINK_CFG_DEFS_SVH
`define OFS_LINK_RATE_CODE 12'h000
`define OFS_ACTIVE_LANE_COUNT 12'h004
`define OFS_FRAMING_SELECT 12'h008
`define OFS_TRAINING_SELECT 12'h00c
`define OFS_QUALITY_SELECT 12'h010
`define OFS_SCRAMBLER_BYPASS 12'h014
`define OFS_CLOCK_SPREAD 12'h018
`define OFS_SOFT_VIDEO_RESET 12'h01c
`define OFS_LINK_OUTPUT_GATE 12'h080
`define OFS_VIDEO_STREAM_GATE 12'h084
`define OFS_CONFIG_COMMIT 12'h088
`define OFS_STATUS_LOCK 12'h08c
`define OFS_LINK_STATUS 12'h090
`define RATE_CODE_1G62 8'h06
`define RATE_CODE_2G70 8'h0a
`define RATE_CODE_5G40 8'h14
`define LINK_RATE_DIVISOR 20
`define RATE_CODE_W 8
`define LANE_COUNT_W 5
`define FIELD_BIT0 0
`define FIELD_RESET 32'h0000_0000
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10
`endif

// ==== hw/tx_link_cfg_pkg.sv ====
// Types shared by the link configuration bank and its link-side logic.
package tx_link_cfg_pkg;
    typedef enum logic [1:0] {
        TRAIN_OFF,
        TRAIN_CLOCK_RECOVERY,
        TRAIN_EQUALIZE_2,
        TRAIN_EQUALIZE_3
    } training_type;
    typedef enum logic [1:0] {
        QUAL_NONE,
        QUAL_D10_2,
        QUAL_SYMBOL_ERROR,
        QUAL_PRBS7
    } quality_type;
    typedef struct packed {
        logic [7:0] linkRateCode;
        logic [4:0] laneCount;
        logic enhancedFraming;
        training_type trainingPattern;
        quality_type qualityPattern;
        logic scramblerBypass;
        logic clockSpread;
        logic linkOutputGate;
        logic videoStreamGate;
    } link_config_type;
endpackage

// ==== hw/cfg_fifo.sv ====
// Synchronous FIFO with parameterised width and depth, valid and ready on both sides.
`timescale 1ns/10ps
module cfg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("cfg_fifo depth must be a power of two of at least 2");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    logic doWrite;
    logic doRead;
    assign inReady = (wrPtr_q - rdPtr_q) != (AW + 1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData = mem[rdPtr_q[AW-1:0]];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
        end else if (doWrite) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPtr_q <= '0;
        end else if (doRead) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
endmodule

// ==== hw/frame_gate.sv ====
// Holds a requested enable until the next frame boundary, then applies it.
`timescale 1ns/10ps
module frame_gate (
    input wire logic clk,
    input wire logic rst,
    input wire logic request,
    input wire logic frameStart,
    output logic applied
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            applied <= 1'b0;
        end else if (frameStart) begin
            applied <= request;
        end
    end
endmodule

// ==== verif/tx_link_cfg_chk.sv ====
// Concurrent checks on the ports of the link configuration bank.
`timescale 1ns/10ps
module tx_link_cfg_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic vsyncStart,
    input wire tx_link_cfg_pkg::link_config_type linkConfig,
    input wire logic [6:0] linkClockRatio,
    input wire logic videoResetPulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Handshake steps
    // ----------------------------------------
    sequence readTaken;
        arvalid && arready;
    endsequence
    sequence writeTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    ratio_fixed_a: assert property (!$past(rst) |-> linkClockRatio == 7'd20)
        else $error("link clock ratio differs from twenty");
    write_answer_a: assert property (writeTaken |-> ##[1:2] bvalid)
        else $error("write response missing");
    read_answer_a: assert property (readTaken |=> rvalid)
        else $error("read data missing");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed while waiting");
    read_order_a: assert property (rvalid |-> !arready)
        else $error("read accepted while one is pending");
    reset_pulse_a: assert property (videoResetPulse |=> !videoResetPulse)
        else $error("video reset longer than one cycle");
    stream_frame_a: assert property ($changed(linkConfig.videoStreamGate)
        |-> $past(vsyncStart) || $past(vsyncStart, 2))
        else $error("stream gate changed away from a frame boundary");
endmodule

// ==== verif/link_sink_model.sv ====
// Far-side stand-in: frame boundaries and a status word that moves every cycle.
`timescale 1ns/10ps
module link_sink_model #(
    parameter int FRAME_LEN = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire tx_link_cfg_pkg::link_config_type linkConfig,
    output logic vsyncStart,
    output logic [15:0] symbolStatus
);
    int frameCount_q;
    // A status word that never rests makes a missing freeze visible.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frameCount_q <= 0;
            vsyncStart <= 1'b0;
            symbolStatus <= 16'h0000;
        end else begin
            frameCount_q <= (frameCount_q == FRAME_LEN - 1) ? 0 : frameCount_q + 1;
            vsyncStart <= (frameCount_q == FRAME_LEN - 1);
            symbolStatus <= symbolStatus + 16'h0001 + {11'h000, linkConfig.laneCount};
        end
    end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the link configuration bank.
`timescale 1ns/10ps
`include "tx_link_cfg_defs.svh"
module testbench;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, vsyncStart, videoResetPulse;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] symbolStatus;
    logic [6:0] linkClockRatio;
    tx_link_cfg_pkg::link_config_type linkConfig, expCfg, prevCfg, cfgNoV12, expNoV12;
    int errTotal, checkCount, cycles, pulses, i, j, k;
    int seed = 32'h7451515d;
    logic [1:0] expB[$];
    logic [33:0] expR[$];
    logic [31:0] val[9];
    logic [11:0] offs[9] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
        12'h014, 12'h018, 12'h080, 12'h084};
    logic [31:0] masks[9] = '{32'hff, 32'h1f, 32'h1, 32'h3, 32'h3, 32'h1, 32'h1, 32'h1, 32'h1};
    logic [7:0] rates[3] = '{8'h06, 8'h0a, 8'h14};
    logic [4:0] lanes[3] = '{5'h01, 5'h02, 5'h04};
    tx_link_config_registers i_dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .vsyncStart(vsyncStart), .symbolStatus(symbolStatus), .linkConfig(linkConfig),
        .linkClockRatio(linkClockRatio), .videoResetPulse(videoResetPulse));
    link_sink_model i_sink (.clk(clk), .rst(rst), .linkConfig(linkConfig),
        .vsyncStart(vsyncStart), .symbolStatus(symbolStatus));
    // The same traffic into a core without the newer protocol version exercises the fallbacks.
    tx_link_config_registers #(.SUPPORTS_V12(1'b0)) i_dut_v11 (.clk(clk), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(), .rdata(), .rresp(), .rvalid(), .rready(rready),
        .vsyncStart(vsyncStart), .symbolStatus(symbolStatus), .linkConfig(cfgNoV12),
        .linkClockRatio(), .videoResetPulse());
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // Bus tasks and comparisons
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk) #1;
        awaddr = a;
        wdata = d;
        awvalid = 1'b1;
        wvalid = 1'b1;
        expB.push_back(r);
        do @(posedge clk); while (!(awready && wready));
        #1 awvalid = 1'b0;
        wvalid = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        @(posedge clk) #1;
        araddr = a;
        arvalid = 1'b1;
        expR.push_back(e);
        do @(posedge clk); while (!arready);
        #1 arvalid = 1'b0;
    endtask
    task automatic cmpResp(input string n, input logic [1:0] e, input logic [1:0] g);
        checkCount++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmpWord(input string n, input logic [33:0] e, input logic [33:0] g);
        checkCount++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmpCfg(input string n, input logic [21:0] e, input logic [21:0] g);
        checkCount++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finishTest;
        if (errTotal == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Response watcher, slow host and watchdog
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst && bvalid && bready) cmpResp("write response", expB.pop_front(), bresp);
        if (!rst && rvalid && rready) cmpWord("read word", expR.pop_front(), {rresp, rdata});
        if (!rst && videoResetPulse) pulses++;
        cycles++;
        if (cycles == 6000) begin
            errTotal++;
            finishTest();
        end
    end
    // Random ready keeps responses waiting now and then.
    always @(posedge clk) begin
        #1 bready = 1'($random(seed));
        rready = 1'($random(seed));
    end
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid, bready, rready} = '0;
        wstrb = 4'hf;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        for (i = 0; i < 9; i++) rd(offs[i], 34'h0);
        rd(12'h040, {2'b10, 32'h0});
        wr(12'h040, $random(seed), 2'b10);
        rd(12'h040, {2'b10, 32'h0});
        wr(`OFS_STATUS_LOCK, $random(seed) | 32'h1, 2'b00);
        rd(`OFS_STATUS_LOCK, 34'h1);
        wr(`OFS_STATUS_LOCK, {$random(seed)} & 32'hffff_fffe, 2'b00);
        rd(`OFS_STATUS_LOCK, 34'h0);
        prevCfg = '0;
        for (k = 0; k < 4; k++) begin
            for (j = 0; j < 9; j++) val[j] = $random(seed) & masks[j];
            val[0] = {24'h0, rates[k % 3]};
            val[1] = {27'h0, lanes[k % 3]};
            val[3] = k;
            val[4] = 3 - k;
            for (j = 0; j < 9; j++) wr(offs[j], ($random(seed) & ~masks[j]) | val[j], 2'b00);
            for (j = 0; j < 9; j++) rd(offs[j], {2'b00, val[j]});
            repeat (12) @(posedge clk);
            #1 cmpCfg("config before commit", prevCfg, linkConfig);
            wr(`OFS_CONFIG_COMMIT, $random(seed), 2'b00);
            expCfg = {val[0][7:0], val[1][4:0], val[2][0], val[3][1:0], val[4][1:0],
                val[5][0], val[6][0], val[7][0], val[8][0]};
            expNoV12 = expCfg;
            if (expCfg.linkRateCode == `RATE_CODE_5G40) expNoV12.linkRateCode = `RATE_CODE_2G70;
            if (expCfg.trainingPattern == tx_link_cfg_pkg::TRAIN_EQUALIZE_3) begin
                expNoV12.trainingPattern = tx_link_cfg_pkg::TRAIN_EQUALIZE_2;
            end
            repeat (12) @(posedge clk);
            do @(posedge clk); while (!vsyncStart);
            repeat (3) @(posedge clk);
            #1 cmpCfg("applied config", expCfg, linkConfig);
            cmpCfg("fallback config", expNoV12, cfgNoV12);
            rd(`OFS_CONFIG_COMMIT, {33'h0, 1'(k + 1)});
            prevCfg = expCfg;
        end
        wr(12'h01c, {$random(seed)} & 32'hffff_fffe, 2'b00);
        wr(12'h01c, $random(seed) | 32'h1, 2'b00);
        rd(12'h01c, 34'h0);
        repeat (6) @(posedge clk);
        cmpWord("video reset pulses", 34'h1, pulses);
        finishTest();
    end
endmodule
bind tx_link_config_registers tx_link_cfg_chk i_chk (.clk(clk), .rst(rst), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .vsyncStart(vsyncStart), .linkConfig(linkConfig),
    .linkClockRatio(linkClockRatio), .videoResetPulse(videoResetPulse));
